// [uart_frame_defines.svh]
// Constants of the UART frame engine: encodings, last data bit indices, reset values.
// How it works
// [RQ1] Software configures fields, then power, then enables.
// [RQ2] Enables and port settings pick pin functions.
// [RQ3] Frame: start, 7/8 bits, parity, 1/2 stops.
// [RQ4] Length, parity, stops come from mode fields.
// [RQ5] Bit-order field selects first shifted bit.
// [RQ6] Inversion field inverts the transmit pin waveform.
// [RQ7] Even parity: odd ones gives parity one.
// [RQ8] Even parity receive: odd total flags error.
// [RQ9] Odd parity: odd ones gives parity zero.
// [RQ10] Odd parity receive: even total flags error.
// [RQ11] Zero parity sends zero, receiver never errs.
// [RQ12] No parity: no slot, never an error.
// [RQ13] Powered transmit pin idles high until enabled; the code drives out_pin_latch on the pin until then.
// [RQ14] Buffer write while enabled starts a frame.
// [RQ15] Buffer moves to shifter, shifted bit-serially.
// [RQ16] Completion pulse when last stop bit ends.
// [RQ17] Line stays high until next buffer write.
// [RQ18] On LIN bus software selects no parity.
// [RQ19] Order zero is MSB first, one LSB.
// [RQ20] Power off resets engine, pins forced high.
// [RQ21] Receiver checks only one stop bit.
// [RQ22] Each bit lasts one period; parity before stops.
`ifndef UART_FRAME_DEFINES_SVH
`define UART_FRAME_DEFINES_SVH
`define PAR_NONE     2'h0
`define PAR_ZERO     2'h1
`define PAR_ODD      2'h2
`define PAR_EVEN     2'h3
`define ORDER_MSB    1'h0
`define LEN_SEVEN    3'h6
`define LEN_EIGHT    3'h7
`define BAUD_MIN     8'h01
`define BAUD_ONE     8'h01
`define CHAR_RESET   8'h00
`define LINE_IDLE    1'h1
`define DIR_OUTPUT   1'h0
`define DIR_INPUT    1'h1
`endif

// [uart_frame_pkg.sv]
// Types shared by the UART frame engine.
package uart_frame_pkg;
   // Operation mode fields
   typedef struct packed {
      logic unit_power_enable;
      logic transmit_enable;
      logic receive_enable;
      logic parity_select_hi;
      logic parity_select_lo;
      logic character_length;  // 1: eight bits
      logic stop_length;       // 1: two stop bits
      logic error_irq_merge;
   } mode_cfg_s;
   // Line control fields
   typedef struct packed {
      logic bit_order_select;  // 0: MSB first
      logic tx_output_invert;
   } line_cfg_s;
   // Port settings of the two pins
   typedef struct packed {
      logic out_pin_direction; // 0: output
      logic out_pin_latch;
      logic in_pin_direction;  // 1: input
   } port_cfg_s;
   // Frame sequencer states
   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} frame_st_e;
endpackage : uart_frame_pkg

// [uart_frame_engine.sv]
// UART frame engine: transmit and receive framing, parity, pin routing.
`timescale 1ns/1ps
`include "uart_frame_defines.svh"
module uart_frame_engine
   import uart_frame_pkg::*;
(
   input  wire logic       clk,              // 10 MHz clock
   input  wire logic       reset,            // Async reset, active high
   input  wire mode_cfg_s  mode,             // Operation mode fields
   input  wire line_cfg_s  line_cfg,         // Bit order and inversion
   input  wire port_cfg_s  port_cfg,         // Pin direction and latch
   input  wire logic [7:0] baud_divisor,     // Clocks per bit
   input  wire logic       tx_write,         // Transmit buffer write strobe
   input  wire logic [7:0] tx_data,          // Transmit buffer data
   input  wire logic       serial_in_pin,    // Receive pin level
   output logic            serial_out_o,     // Transmit pin level
   output logic            serial_out_oe,    // Transmit pin drive enable
   output logic            tx_complete_irq,  // Frame done pulse
   output logic            tx_busy,          // Frame in progress
   output logic            rx_routed,        // Receive pin serves the UART
   output logic [7:0]      rx_data,          // Received character
   output logic            rx_valid,         // Character received pulse
   output logic            rx_parity_error,  // Parity error with rx_valid
   output logic            rx_framing_error  // Stop bit low with rx_valid
);
   // Returns character masked to length, bit-reversed when MSB first
   function automatic logic [7:0] order_char(input logic [7:0] d, input logic len8,
                                             input logic msb);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         r[i] = d[7-i];
      end
      if (!msb) begin
         order_char = len8 ? d : {1'b0, d[6:0]};
      end else begin
         order_char = len8 ? r : {1'b0, r[7:1]};
      end
   endfunction : order_char

   // Bit period in clocks, never below one
   function automatic logic [7:0] bit_period(input logic [7:0] div);
      bit_period = (div < `BAUD_MIN) ? `BAUD_MIN : div;
   endfunction : bit_period

   // Decoded configuration
   wire logic       power_on  = mode.unit_power_enable;
   wire logic       tx_on     = power_on & mode.transmit_enable;
   wire logic       rx_on     = power_on & mode.receive_enable;
   wire logic [1:0] par_mode  = {mode.parity_select_hi, mode.parity_select_lo};   // RQ4
   wire logic       len8      = mode.character_length;
   wire logic [2:0] last_bit  = len8 ? `LEN_EIGHT : `LEN_SEVEN;
   wire logic       msb_first = (line_cfg.bit_order_select == `ORDER_MSB);     // RQ19
   wire logic [7:0] period    = bit_period(baud_divisor);
   wire logic       tx_pin_uart = tx_on & (port_cfg.out_pin_direction == `DIR_OUTPUT)
                                  & port_cfg.out_pin_latch;                   // RQ2
   wire logic       rx_pin_uart = rx_on & (port_cfg.in_pin_direction == `DIR_INPUT); // RQ2

   // Transmit registers
   frame_st_e   tx_st_q;                // Transmit sequencer state
   logic [7:0]  tx_sh_q;                // Transmit shifter
   logic [7:0]  tx_chr_q;               // Character in flight, for parity
   logic [7:0]  tx_cnt_q;               // Clocks left in bit
   logic [2:0]  tx_bit_q;               // Bit index in data or stop phase
   logic        tx_par_q;               // Parity bit value
   logic        serial_out_q;           // Registered pin level
   logic        serial_oe_q;            // Registered pin enable
   logic        tx_irq_q;               // Completion pulse
   logic        tx_busy_q;              // Busy flag

   wire logic tx_tick  = (tx_cnt_q == 8'h00);
   wire logic tx_start = tx_write & tx_on & (tx_st_q == ST_IDLE);          // RQ14
   wire logic [7:0] tx_load = order_char(tx_data, len8, msb_first);        // RQ5
   wire logic tx_chr_par = ^order_char(tx_data, len8, 1'b0);
   wire logic tx_par_d = (par_mode == `PAR_EVEN) ? tx_chr_par :            // RQ7
                         (par_mode == `PAR_ODD)  ? ~tx_chr_par : 1'b0;     // RQ9 RQ11
   wire logic tx_last_stop = (tx_st_q == ST_STOP) & tx_tick
                             & (tx_bit_q == {2'b00, mode.stop_length});    // RQ3

   // Serial level of the current bit
   logic tx_line;
   always_comb begin
      case (tx_st_q)
         ST_START: tx_line = 1'b0;
         ST_DATA:  tx_line = tx_sh_q[0];
         ST_PAR:   tx_line = tx_par_q;                                     // RQ22
         default:  tx_line = `LINE_IDLE;                                   // RQ13 RQ17
      endcase
   end

   // Transmit sequencer; power or enable off clears it synchronously
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tx_st_q  <= ST_IDLE;
         tx_sh_q  <= `CHAR_RESET;
         tx_chr_q <= `CHAR_RESET;
         tx_cnt_q <= 8'h00;
         tx_bit_q <= 3'h0;
         tx_par_q <= 1'b0;
      end else if (!tx_on) begin
         tx_st_q  <= ST_IDLE;                                              // RQ20
         tx_cnt_q <= 8'h00;
         tx_bit_q <= 3'h0;
      end else if (tx_start) begin
         // Buffer contents move into the shifter
         tx_st_q  <= ST_START;                                             // RQ15
         tx_sh_q  <= tx_load;
         tx_chr_q <= order_char(tx_data, len8, 1'b0);
         tx_par_q <= tx_par_d;
         tx_cnt_q <= period - `BAUD_ONE;
         tx_bit_q <= 3'h0;
      end else if (tx_st_q != ST_IDLE) begin
         if (!tx_tick) begin
            tx_cnt_q <= tx_cnt_q - 8'h01;                                  // RQ22
         end else begin
            tx_cnt_q <= period - `BAUD_ONE;
            case (tx_st_q)
               ST_START: begin
                  tx_st_q <= ST_DATA;
               end
               ST_DATA: begin
                  tx_sh_q  <= {1'b0, tx_sh_q[7:1]};                        // RQ15
                  tx_bit_q <= tx_bit_q + 3'h1;
                  if (tx_bit_q == last_bit) begin
                     tx_bit_q <= 3'h0;
                     tx_st_q  <= (par_mode == `PAR_NONE) ? ST_STOP : ST_PAR; // RQ12
                  end
               end
               ST_PAR: begin
                  tx_st_q <= ST_STOP;
               end
               ST_STOP: begin
                  tx_bit_q <= tx_bit_q + 3'h1;
                  if (tx_last_stop) begin
                     tx_st_q <= ST_IDLE;                                   // RQ17
                  end
               end
               default: begin
                  tx_st_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Pin drive, completion pulse and busy flag
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         serial_out_q <= `LINE_IDLE;
         serial_oe_q  <= 1'b0;
         tx_irq_q     <= 1'b0;
         tx_busy_q    <= 1'b0;
      end else begin
         serial_out_q <= tx_pin_uart ? (tx_line ^ line_cfg.tx_output_invert)  // RQ6
                                     : (power_on ? port_cfg.out_pin_latch : `LINE_IDLE); // RQ20
         serial_oe_q  <= (port_cfg.out_pin_direction == `DIR_OUTPUT);
         tx_irq_q     <= tx_on & tx_last_stop & ~tx_start;                 // RQ16
         tx_busy_q    <= tx_on & (tx_start | (tx_st_q != ST_IDLE)) & ~tx_last_stop;
      end
   end

   // Receive pin synchroniser; unrouted or unpowered input reads high
   logic rx_s1_q;                        // First stage
   logic rx_s2_q;                        // Second stage
   logic rx_prev_q;                      // Previous synchronised level
   // Level seen by the receiver; forced high while unpowered or unrouted
   wire logic rx_in = rx_pin_uart ? rx_s2_q : `LINE_IDLE;                  // RQ20
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_s1_q   <= `LINE_IDLE;
         rx_s2_q   <= `LINE_IDLE;
         rx_prev_q <= `LINE_IDLE;
      end else begin
         rx_s1_q   <= serial_in_pin;
         rx_s2_q   <= rx_s1_q;
         rx_prev_q <= rx_in;
      end
   end
   // Receive registers
   frame_st_e   rx_st_q;                // Receive sequencer state
   logic [7:0]  rx_sh_q;                // Receive shifter
   logic [7:0]  rx_cnt_q;               // Clocks to next sample
   logic [2:0]  rx_bit_q;               // Data bit index
   logic        rx_acc_q;               // Running ones parity
   logic [7:0]  rx_data_q;              // Received character
   logic        rx_valid_q;             // Done pulse
   logic        rx_perr_q;              // Parity error
   logic        rx_ferr_q;              // Framing error
   logic        rx_routed_q;            // Routing flag

   wire logic rx_tick = (rx_cnt_q == 8'h00);
   wire logic rx_fall = rx_prev_q & ~rx_in;
   wire logic [7:0] rx_norm = len8 ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
   wire logic rx_stop = (rx_st_q == ST_STOP) & rx_tick;                    // RQ21
   wire logic rx_perr_d = ((par_mode == `PAR_EVEN) &  rx_acc_q) |          // RQ8
                          ((par_mode == `PAR_ODD)  & ~rx_acc_q);           // RQ10 RQ11

   // Receive sequencer, sampling at mid-bit
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_st_q  <= ST_IDLE;
         rx_sh_q  <= `CHAR_RESET;
         rx_cnt_q <= 8'h00;
         rx_bit_q <= 3'h0;
         rx_acc_q <= 1'b0;
      end else if (!rx_on) begin
         rx_st_q  <= ST_IDLE;                                              // RQ20
         rx_cnt_q <= 8'h00;
      end else if (rx_st_q == ST_IDLE) begin
         if (rx_fall) begin
            rx_st_q  <= ST_START;
            rx_cnt_q <= {1'b0, period[7:1]};
            rx_acc_q <= 1'b0;
            rx_bit_q <= 3'h0;
         end
      end else if (!rx_tick) begin
         rx_cnt_q <= rx_cnt_q - 8'h01;
      end else begin
         rx_cnt_q <= period - `BAUD_ONE;                                   // RQ22
         case (rx_st_q)
            ST_START: begin
               rx_st_q <= rx_in ? ST_IDLE : ST_DATA;
            end
            ST_DATA: begin
               rx_sh_q  <= {rx_in, rx_sh_q[7:1]};
               rx_acc_q <= rx_acc_q ^ rx_in;
               rx_bit_q <= rx_bit_q + 3'h1;
               if (rx_bit_q == last_bit) begin
                  rx_st_q <= (par_mode == `PAR_NONE) ? ST_STOP : ST_PAR;   // RQ12
               end
            end
            ST_PAR: begin
               rx_acc_q <= rx_acc_q ^ rx_in;                               // RQ8 RQ10
               rx_st_q  <= ST_STOP;
            end
            default: begin
               rx_st_q <= ST_IDLE;                                         // RQ21
            end
         endcase
      end
   end

   // Receive results
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_data_q   <= `CHAR_RESET;
         rx_valid_q  <= 1'b0;
         rx_perr_q   <= 1'b0;
         rx_ferr_q   <= 1'b0;
         rx_routed_q <= 1'b0;
      end else begin
         rx_valid_q  <= rx_on & rx_stop;
         rx_routed_q <= rx_pin_uart;
         if (rx_on & rx_stop) begin
            rx_data_q <= order_char(rx_norm, len8, msb_first);             // RQ5
            rx_perr_q <= rx_perr_d;                                        // RQ11 RQ12
            rx_ferr_q <= ~rx_in;
         end
      end
   end

   assign serial_out_o     = serial_out_q;
   assign serial_out_oe    = serial_oe_q;
   assign tx_complete_irq  = tx_irq_q;
   assign tx_busy          = tx_busy_q;
   assign rx_routed        = rx_routed_q;
   assign rx_data          = rx_data_q;
   assign rx_valid         = rx_valid_q;
   assign rx_parity_error  = rx_perr_q;
   assign rx_framing_error = rx_ferr_q;

   // Checks
   property p_idle_high;
      @(posedge clk) disable iff (reset)
      (tx_st_q == ST_IDLE && !tx_start && tx_pin_uart && !line_cfg.tx_output_invert)
         |=> serial_out_q;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("idle line not high"); // RQ13

   property p_start_low;
      @(posedge clk) disable iff (reset)
      (tx_start && tx_pin_uart && !line_cfg.tx_output_invert) |=> ##1 !serial_out_q;
   endproperty
   a_start_low: assert property (p_start_low) else $error("start bit not low"); // RQ14

   property p_irq_after_stop;
      @(posedge clk) disable iff (reset)
      tx_irq_q |-> ($past(tx_st_q) == ST_STOP) && (tx_st_q == ST_IDLE);
   endproperty
   a_irq_after_stop: assert property (p_irq_after_stop) else $error("irq not at stop end"); // RQ16

   property p_stay_idle;
      @(posedge clk) disable iff (reset)
      (tx_irq_q && !tx_write) |-> (tx_st_q == ST_IDLE) ##1 (tx_st_q == ST_IDLE);
   endproperty
   a_stay_idle: assert property (p_stay_idle) else $error("left idle without write"); // RQ17

   property p_par_even;
      @(posedge clk) disable iff (reset)
      (tx_st_q == ST_PAR && par_mode == `PAR_EVEN) |-> (tx_line == ^tx_chr_q);
   endproperty
   a_par_even: assert property (p_par_even) else $error("even parity wrong"); // RQ7

   property p_par_odd;
      @(posedge clk) disable iff (reset)
      (tx_st_q == ST_PAR && par_mode == `PAR_ODD) |-> (tx_line != ^tx_chr_q);
   endproperty
   a_par_odd: assert property (p_par_odd) else $error("odd parity wrong"); // RQ9

   property p_par_zero;
      @(posedge clk) disable iff (reset)
      rx_valid_q && ((par_mode == `PAR_ZERO) || (par_mode == `PAR_NONE)) |-> !rx_perr_q;
   endproperty
   a_par_zero: assert property (p_par_zero) else $error("spurious parity error"); // RQ11

   property p_no_par_slot;
      @(posedge clk) disable iff (reset)
      (par_mode == `PAR_NONE) |-> (tx_st_q != ST_PAR) && (rx_st_q != ST_PAR);
   endproperty
   a_no_par_slot: assert property (p_no_par_slot) else $error("parity slot in none mode"); // RQ12

   property p_power_off;
      @(posedge clk) disable iff (reset)
      !power_on |=> (tx_st_q == ST_IDLE) && (rx_st_q == ST_IDLE) && serial_out_q;
   endproperty
   a_power_off: assert property (p_power_off) else $error("power off not reset"); // RQ20

   property p_bit_length;
      @(posedge clk) disable iff (reset)
      (tx_start && baud_divisor == 8'h04 && $stable(baud_divisor))
         |=> (tx_st_q == ST_START)[*4] ##1 (tx_st_q != ST_START);
   endproperty
   a_bit_length: assert property (p_bit_length) else $error("bit period wrong"); // RQ22

   // Drive enable follows the port direction, and receive routing the port direction with power and receive enable, one cycle later
   property p_pin_route;
      @(posedge clk) disable iff (reset)
      1'b1 |=> (serial_oe_q == $past(port_cfg.out_pin_direction == `DIR_OUTPUT))
               && (rx_routed_q == $past(rx_pin_uart));
   endproperty
   a_pin_route: assert property (p_pin_route) else $error("pin routing wrong"); // RQ2
endmodule : uart_frame_engine

// [uart_remote_station.sv]
// Remote serial station model: drives the receive line and decodes the transmit line.
`timescale 1ns/1ps
module uart_remote_station #(
   parameter int BIT_CLKS = 4           // Clocks per serial bit
) (
   input  wire logic        clk,        // Bench clock
   input  wire logic        listen,     // Decode frames seen on line_in
   input  wire logic        inv,        // Line arrives inverted
   input  wire logic [3:0]  nbits,      // Bits in one decoded frame
   input  wire logic        line_in,    // Transmit line of the block
   output logic             line_out,   // Receive line of the block
   output logic [11:0]      cap,        // Last decoded frame, first bit at 0
   output int               frames      // Count of decoded frames
);
   logic [11:0] cap_w;                  // Frame under capture

   // Line idles high, as a pulled-up serial line does
   initial begin
      line_out = 1'h1;
      cap      = 12'hfff;
      frames   = 0;
   end

   // Send bits in time order, each held for one bit period
   task automatic send(input logic [11:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         line_out <= v[i];
         repeat (BIT_CLKS) @(posedge clk);
      end
      line_out <= 1'h1;
   endtask : send

   // Decode: after a falling start edge, sample each bit in its middle
   always begin
      @(posedge clk);
      if (listen === 1'h1 && (line_in ^ inv) === 1'h0) begin
         cap_w = 12'hfff;
         repeat (BIT_CLKS / 2) @(posedge clk);
         for (int i = 0; i < nbits; i++) begin
            if (i > 0) repeat (BIT_CLKS) @(posedge clk);
            cap_w[i] = line_in ^ inv;
         end
         cap    <= cap_w;
         frames <= frames + 1;
      end
   end
endmodule : uart_remote_station

// [tb_uart_frame_engine.sv]
// Self-checking testbench of the UART frame engine with a remote station model.
`timescale 1ns/1ps
`include "uart_frame_defines.svh"
module tb_uart_frame_engine;
   import uart_frame_pkg::*;
   localparam int P = 4;                // Clocks per serial bit
   logic        clk, reset, tx_write, listen, inv, serial_in_pin;
   logic        serial_out_o, serial_out_oe, tx_complete_irq, tx_busy, rx_routed;
   logic        rx_valid, rx_parity_error, rx_framing_error, rx_perr, rx_ferr;
   mode_cfg_s   mode;                   // Operation mode fields
   line_cfg_s   line_cfg;               // Bit order and inversion
   port_cfg_s   port_cfg;               // Pin settings
   logic [7:0]  baud_divisor, tx_data, rx_data, rx_last;
   logic [3:0]  nbits;                  // Frame length for the station
   logic [11:0] cap;                    // Frame decoded by the station
   int          frames, err_total, samples_checked, cycles, rx_count;

   uart_frame_engine i_uart_frame_engine (.clk(clk), .reset(reset), .mode(mode),
      .line_cfg(line_cfg), .port_cfg(port_cfg), .baud_divisor(baud_divisor),
      .tx_write(tx_write), .tx_data(tx_data), .serial_in_pin(serial_in_pin),
      .serial_out_o(serial_out_o), .serial_out_oe(serial_out_oe),
      .tx_complete_irq(tx_complete_irq), .tx_busy(tx_busy), .rx_routed(rx_routed),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_parity_error(rx_parity_error),
      .rx_framing_error(rx_framing_error));
   uart_remote_station #(.BIT_CLKS(P)) i_uart_remote_station (.clk(clk), .listen(listen),
      .inv(inv), .nbits(nbits), .line_in(serial_out_o), .line_out(serial_in_pin),
      .cap(cap), .frames(frames));

   // 100 ns clock
   initial clk = 1'h0;
   always #50 clk = ~clk;

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         close_out();
      end
   end

   // Keep what each received character pulse carries
   always @(posedge clk) begin
      if (rx_valid === 1'h1) begin
         rx_count <= rx_count + 1;
         rx_last  <= rx_data;
         rx_perr  <= rx_parity_error;
         rx_ferr  <= rx_framing_error;
      end
   end

   // Compare and count
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Expected frame bits in time order, unused upper bits high
   function automatic logic [11:0] build(input logic [7:0] d, input logic len8,
      input logic [1:0] par, input logic stop2, input logic msb, output int n);
      logic [11:0] v;
      logic [7:0]  dd;
      int          nc;
      nc = len8 ? 8 : 7;
      dd = len8 ? d : {1'h0, d[6:0]};
      v = 12'hffe;
      for (int i = 0; i < nc; i++) v[1 + i] = msb ? dd[nc - 1 - i] : dd[i];
      if (par == `PAR_EVEN) v[1 + nc] = ^dd;
      if (par == `PAR_ODD) v[1 + nc] = ~^dd;
      if (par == `PAR_ZERO) v[1 + nc] = 1'h0;
      n = 2 + nc + int'(par != `PAR_NONE) + int'(stop2);
      return v;
   endfunction : build

   // Fields first, then power, then the enables
   task automatic cfg(input logic pw, te, re, input logic [1:0] par,
      input logic len8, stop2, msb, inv_v);
      @(posedge clk);
      mode     <= {3'h0, par, len8, stop2, 1'h0};
      line_cfg <= {~msb, inv_v};
      inv      <= inv_v;
      @(posedge clk);
      mode.unit_power_enable <= pw;
      @(posedge clk);
      mode.transmit_enable <= te;
      mode.receive_enable  <= re;
      repeat (3) @(posedge clk);
   endtask : cfg

   // Pin routing, idle levels, refused write
   task automatic pins();
      port_cfg <= 3'h1;
      cfg(0, 0, 0, `PAR_NONE, 1, 0, 0, 0);
      chk(serial_out_o, 1);
      chk(rx_routed, 0);
      cfg(1, 0, 1, `PAR_NONE, 1, 0, 0, 0);
      chk(rx_routed, 1);
      chk(serial_out_o, 0);
      chk(serial_out_oe, 1);
      tx_write <= 1'h1;
      @(posedge clk);
      tx_write <= 1'h0;
      repeat (3) @(posedge clk);
      chk(tx_busy, 0);
      port_cfg <= 3'h7;
      cfg(1, 1, 0, `PAR_NONE, 1, 0, 0, 0);
      chk(serial_out_oe, 0);
      port_cfg <= 3'h3;
      cfg(1, 1, 0, `PAR_NONE, 1, 0, 0, 0);
      chk(serial_out_o, 1);
   endtask : pins

   // One transmitted frame, with a write during the frame that must be ignored
   task automatic do_tx(input logic [1:0] par, input logic len8, stop2, msb, inv_v,
      input logic [7:0] d);
      logic [11:0] v;
      int          n, k, f0;
      v = build(d, len8, par, stop2, msb, n);
      cfg(1, 1, 0, par, len8, stop2, msb, inv_v);
      nbits  <= 4'(n);
      listen <= 1'h1;
      f0 = frames;
      tx_data  <= d;
      tx_write <= 1'h1;
      @(posedge clk);
      tx_write <= 1'h0;
      k = 0;
      while (tx_complete_irq !== 1'h1 && k < 200) begin
         @(posedge clk);
         k++;
         if (k == 3) chk(tx_busy, 1);
         tx_write <= (k == 5);
         tx_data  <= ~d;
      end
      chk(k >= P * n && k <= P * n + 3, 1);
      chk(cap, v);
      repeat (3 * P) @(posedge clk);
      chk(12'(frames - f0), 12'h1);
      chk(serial_out_o ^ inv_v, 1);
      listen <= 1'h0;
   endtask : do_tx

   // One received frame sent by the station with a single stop bit
   task automatic do_rx(input logic [1:0] par, input logic msb, stop2,
      input logic [7:0] d, input logic flip, perr);
      logic [11:0] v;
      int          n, c0;
      v = build(d, 1'h1, par, 1'h0, msb, n);
      v[9] = v[9] ^ flip;
      cfg(1, 0, 1, par, 1, stop2, msb, 0);
      c0 = rx_count;
      i_uart_remote_station.send(v, n);
      repeat (P) @(posedge clk);
      chk(12'(rx_count - c0), 12'h1);
      chk(rx_last, d);
      chk(rx_perr, perr);
      chk(rx_ferr, 0);
   endtask : do_rx

   // Counts and verdict
   task close_out();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : close_out

   // Main sequence
   initial begin
      reset = 1'h1;
      {tx_write, listen, inv, rx_perr, rx_ferr} = 5'h0;
      {mode, line_cfg, tx_data, rx_last, nbits} = 30'h0;
      port_cfg = 3'h3;
      baud_divisor = 8'(P);
      {err_total, samples_checked, cycles, rx_count} = {4{32'h0}};
      repeat (12) @(posedge clk);
      reset <= 1'h0;
      pins();
      do_tx(`PAR_EVEN, 1, 0, 0, 0, 8'h55);
      do_tx(`PAR_EVEN, 1, 0, 1, 1, 8'h55);
      do_tx(`PAR_ODD, 0, 1, 0, 0, 8'h36);
      do_tx(`PAR_NONE, 1, 0, 0, 0, 8'h87);
      do_tx(`PAR_ZERO, 1, 1, 1, 0, 8'ha5);
      do_rx(`PAR_EVEN, 0, 0, 8'h55, 0, 0);
      do_rx(`PAR_EVEN, 1, 0, 8'h55, 1, 1);
      do_rx(`PAR_ODD, 0, 1, 8'h3c, 0, 0);
      do_rx(`PAR_ODD, 0, 0, 8'h3c, 1, 1);
      do_rx(`PAR_ZERO, 1, 0, 8'h81, 1, 0);
      do_rx(`PAR_NONE, 0, 1, 8'h87, 0, 0);
      close_out();
   end
endmodule : tb_uart_frame_engine
